// ### include/xma_pkg.sv
// xma_pkg: opcodes, flag positions, widths and reset values for the
// extended data-memory alu.
// assumes: used by logic/xma_alu.sv and the testbench, referenced with xma_pkg:: names.
package xma_pkg;
    // data width of working register, memory byte and operands
    localparam int DW = 8;
    // bit index width for single-bit forms
    localparam int BW = 3;
    // reset value of the working register and memory write data
    localparam logic [7:0] WORK_RST = 8'h00;
    // value written by the set-all form
    localparam logic [7:0] ALL_ONES = 8'hFF;
    // one, for increment and decrement
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // flag positions inside the status byte
    localparam int FLG_C  = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_SC = 4;
    localparam int FLG_CZ = 5;
    localparam logic [5:0] FLAG_RST = 6'h00;

    // operation codes
    typedef enum logic [4:0] {
        OP_NONE              = 5'h00,
        OP_OR_INTO_MEMORY    = 5'h01,
        OP_ROT_LEFT_MEM      = 5'h02,
        OP_ROT_LEFT_WORK     = 5'h03,
        OP_ROT_LEFT_C_MEM    = 5'h04,
        OP_ROT_LEFT_C_WORK   = 5'h05,
        OP_ROT_RIGHT_MEM     = 5'h06,
        OP_ROT_RIGHT_WORK    = 5'h07,
        OP_ROT_RIGHT_C_MEM   = 5'h08,
        OP_ROT_RIGHT_C_WORK  = 5'h09,
        OP_SUB_BORROW_WORK   = 5'h0A,
        OP_SUB_BORROW_MEM    = 5'h0B,
        OP_DEC_SKIP_MEM      = 5'h0C,
        OP_DEC_SKIP_WORK     = 5'h0D,
        OP_SET_ALL_MEM       = 5'h0E,
        OP_SET_BIT_MEM       = 5'h0F,
        OP_INC_SKIP_MEM      = 5'h10,
        OP_INC_SKIP_WORK     = 5'h11,
        OP_SKIP_NZ_BIT       = 5'h12,
        OP_SKIP_NZ_BYTE      = 5'h13,
        OP_SUB_WORK          = 5'h14,
        OP_SUB_MEM           = 5'h15,
        OP_SWAP_MEM          = 5'h16,
        OP_SWAP_WORK         = 5'h17
    } xma_op_e;

    // execution phase: normal or dummy cycle after a skip
    typedef enum logic {
        PH_RUN   = 1'b0,
        PH_DUMMY = 1'b1
    } xma_ph_e;
endpackage

// ### logic/xma_alu.sv
// xma_alu: executes the memory-direct part of the extended instruction
// set, holding the working register and the alu flags.
// assumes: the sequencer presents one opcode with its memory byte and bit
// index while i_op_valid is high, writes o_mem_wdata back when o_mem_we
// pulses, and replaces the next instruction while o_skip is high.
//
// How it works
// - or working into memory, zero flag only
// - rotate memory left, bit7 to bit0, no flags
// - same left rotate into working register
// - nine-bit left rotate through carry into memory
// - left rotate through carry into working
// - rotate memory right, bit0 to bit7
// - same right rotate into working register
// - nine-bit right rotate through carry into memory
// - right rotate through carry into working
// - working minus memory minus not carry, all flags
// - same borrow subtract stored to memory
// - decrement memory, skip next when zero
// - decrement into working, skip when zero
// - write all ones to memory byte
// - set one selected memory bit
// - increment memory, skip next when zero
// - increment into working, skip when zero
// - skip when selected bit is one
// - skip when whole byte is nonzero
// - working minus memory into working, all flags
// - same subtract stored to memory
// - swap nibbles into memory or working
`timescale 1ns/1ps
module xma_alu (
    input  wire logic                i_sys_clk,      // system clock
    input  wire logic                i_rst_n,        // async reset, low
    input  wire logic                i_clk_en,       // freezes state when low
    input  wire logic                i_op_valid,     // opcode present
    input  wire logic [4:0]          i_op,           // operation code
    input  wire logic [7:0]          i_mem_rdata,    // addressed byte
    input  wire logic [2:0]          i_bit_sel,      // bit index
    output logic                     o_op_ready,     // can take an opcode
    output logic                     o_mem_we,       // memory write pulse
    output logic [7:0]               o_mem_wdata,    // byte to write
    output logic [7:0]               o_working_register, // working reg
    output logic [5:0]               o_flags,        // status flags
    output logic                     o_skip          // dummy cycle now
);

    ////////////////////////////////////////////////////////////////////
    // state
    // one struct: one comb copy fills it, one register holds it

    // all registered state in one struct
    // the dummy phase sits here too, so a low clock enable also
    // holds a pending skip until the sequencer runs again
    typedef struct packed {
        logic [7:0]       work;     // working register
        logic [5:0]       flags;    // c, ac, z, ov, sc, cz
        logic             we;       // memory write strobe
        logic [7:0]       wdata;    // memory write data
        xma_pkg::xma_ph_e ph;       // run or dummy
    } xma_st_s;

    xma_st_s st_ff;       // current state
    xma_st_s nxt_st;      // next state

    ////////////////////////////////////////////////////////////////////
    // arithmetic helpers
    // shared by the subtract and step forms; the other results are built in the case below

    logic [7:0] m;                  // memory operand
    logic [7:0] w;                  // working operand
    logic       c_in;               // carry in
    logic       borrow_in;          // inverted carry for borrow forms
    logic [8:0] diff;               // nine-bit difference
    logic [4:0] diff_lo;            // low nibble difference
    logic [7:0] dec_v;              // m - 1
    logic [7:0] inc_v;              // m + 1
    logic       ov_v;               // signed overflow of subtract
    logic       sub_is_borrow;      // borrow form selected

    // memory forms read the byte offered now, never their own last
    // write: a back-to-back access to one address needs forwarding
    // in the sequencer
    assign m         = i_mem_rdata;
    assign w         = st_ff.work;
    assign c_in      = st_ff.flags[xma_pkg::FLG_C];
    assign sub_is_borrow = (i_op == xma_pkg::OP_SUB_BORROW_WORK) ||
                           (i_op == xma_pkg::OP_SUB_BORROW_MEM);
    // borrow forms subtract the complement of carry
    assign borrow_in = sub_is_borrow ? ~c_in : 1'b0;
    // nine-bit difference; bit 8 set means the result went negative
    assign diff      = {1'b0, w} - {1'b0, m} - {8'h00, borrow_in};
    // nibble difference; bit 4 set means a borrow out of bit 3
    assign diff_lo   = {1'b0, w[3:0]} - {1'b0, m[3:0]}
                       - {4'h0, borrow_in};
    // step values wrap: 00 minus one is ff, ff plus one is 00,
    // and the zero skip tests depend on that wrap
    assign dec_v     = m - xma_pkg::ONE_BYTE;
    assign inc_v     = m + xma_pkg::ONE_BYTE;
    // overflow: operand signs differ and result sign differs from w
    assign ov_v      = (w[7] ^ m[7]) & (w[7] ^ diff[7]);

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    // one opcode per enabled edge, none during a dummy cycle

    // decode the opcode and compute results, flags and skip
    always_comb begin
        logic [7:0] sub_res;
        logic       z_sub;
        // subtract result and its zero test, shared by four forms
        sub_res = diff[7:0];
        z_sub   = (sub_res == xma_pkg::ZERO_BYTE);
        // defaults: hold every register, drop the write strobe
        nxt_st  = st_ff;
        nxt_st.we = 1'b0;
        if (st_ff.ph == xma_pkg::PH_DUMMY) begin
            // dummy cycle replaces the skipped instruction; an opcode
            // offered now is refused, ready is low
            nxt_st.ph = xma_pkg::PH_RUN;
        end else if (i_op_valid) begin
            // ready is high, so a valid opcode is taken this edge
            unique case (xma_pkg::xma_op_e'(i_op))
                // or into memory; only the zero flag follows the result
                xma_pkg::OP_OR_INTO_MEMORY: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = w | m;
                    nxt_st.flags[xma_pkg::FLG_Z] =
                        ((w | m) == xma_pkg::ZERO_BYTE);
                end
                // plain left rotate written back to memory
                xma_pkg::OP_ROT_LEFT_MEM: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = {m[6:0], m[7]};
                end
                // plain left rotate into working; memory untouched
                xma_pkg::OP_ROT_LEFT_WORK: begin
                    nxt_st.work = {m[6:0], m[7]};
                end
                // nine-bit left rotate through carry, back to memory
                xma_pkg::OP_ROT_LEFT_C_MEM: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = {m[6:0], c_in};
                    nxt_st.flags[xma_pkg::FLG_C] = m[7];
                end
                // nine-bit left rotate through carry into working
                xma_pkg::OP_ROT_LEFT_C_WORK: begin
                    nxt_st.work = {m[6:0], c_in};
                    nxt_st.flags[xma_pkg::FLG_C] = m[7];
                end
                // plain right rotate written back to memory
                xma_pkg::OP_ROT_RIGHT_MEM: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = {m[0], m[7:1]};
                end
                // plain right rotate into working; memory untouched
                xma_pkg::OP_ROT_RIGHT_WORK: begin
                    nxt_st.work = {m[0], m[7:1]};
                end
                // nine-bit right rotate through carry, back to memory
                xma_pkg::OP_ROT_RIGHT_C_MEM: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = {c_in, m[7:1]};
                    nxt_st.flags[xma_pkg::FLG_C] = m[0];
                end
                // nine-bit right rotate through carry into working
                xma_pkg::OP_ROT_RIGHT_C_WORK: begin
                    nxt_st.work = {c_in, m[7:1]};
                    nxt_st.flags[xma_pkg::FLG_C] = m[0];
                end
                // four subtract forms: borrow forms take carry in,
                // memory forms write the byte back
                xma_pkg::OP_SUB_BORROW_WORK,
                xma_pkg::OP_SUB_WORK,
                xma_pkg::OP_SUB_BORROW_MEM,
                xma_pkg::OP_SUB_MEM: begin
                    // destination picked by the memory forms
                    if ((i_op == xma_pkg::OP_SUB_BORROW_MEM) ||
                        (i_op == xma_pkg::OP_SUB_MEM)) begin
                        nxt_st.we    = 1'b1;
                        nxt_st.wdata = sub_res;
                    end else begin
                        nxt_st.work = sub_res;
                    end
                    // carry set when no borrow out
                    nxt_st.flags[xma_pkg::FLG_C]  = ~diff[8];
                    // auxiliary carry set when the nibble needed no borrow
                    nxt_st.flags[xma_pkg::FLG_AC] = ~diff_lo[4];
                    nxt_st.flags[xma_pkg::FLG_Z]  = z_sub;
                    // overflow: the signed result left the byte range
                    nxt_st.flags[xma_pkg::FLG_OV] = ov_v;
                    // signed carry: sign of true result
                    nxt_st.flags[xma_pkg::FLG_SC] = ov_v ^ sub_res[7];
                    // chained zero keeps zero over a borrow chain
                    nxt_st.flags[xma_pkg::FLG_CZ] = sub_is_borrow ?
                        (z_sub & st_ff.flags[xma_pkg::FLG_CZ]) : z_sub;
                end
                // decrement memory; the skip looks at the new value,
                // so only a byte of 01 leads to a dummy cycle
                xma_pkg::OP_DEC_SKIP_MEM: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = dec_v;
                    if (dec_v == xma_pkg::ZERO_BYTE) begin
                        nxt_st.ph = xma_pkg::PH_DUMMY;
                    end
                end
                // decrement into working; memory untouched
                xma_pkg::OP_DEC_SKIP_WORK: begin
                    nxt_st.work = dec_v;
                    if (dec_v == xma_pkg::ZERO_BYTE) begin
                        nxt_st.ph = xma_pkg::PH_DUMMY;
                    end
                end
                // all ones into memory, flags kept
                xma_pkg::OP_SET_ALL_MEM: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = xma_pkg::ALL_ONES;
                end
                // one chosen bit forced high, flags kept
                xma_pkg::OP_SET_BIT_MEM: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = m | (xma_pkg::ONE_BYTE << i_bit_sel);
                    // other bits kept
                    // an eight-bit shift, so index 7 is the top bit
                end
                // increment memory; ff wraps to 00 and skips
                xma_pkg::OP_INC_SKIP_MEM: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = inc_v;
                    if (inc_v == xma_pkg::ZERO_BYTE) begin
                        nxt_st.ph = xma_pkg::PH_DUMMY;
                    end
                end
                // increment into working; memory untouched
                xma_pkg::OP_INC_SKIP_WORK: begin
                    nxt_st.work = inc_v;
                    if (inc_v == xma_pkg::ZERO_BYTE) begin
                        nxt_st.ph = xma_pkg::PH_DUMMY;
                    end
                end
                // skip when the chosen bit is one;
                // no write and no flag change
                xma_pkg::OP_SKIP_NZ_BIT: begin
                    if (m[i_bit_sel]) begin
                        nxt_st.ph = xma_pkg::PH_DUMMY;
                    end
                end
                // skip when any bit of the byte is one
                xma_pkg::OP_SKIP_NZ_BYTE: begin
                    if (m != xma_pkg::ZERO_BYTE) begin
                        nxt_st.ph = xma_pkg::PH_DUMMY;
                    end
                end
                // nibbles exchanged and written back
                xma_pkg::OP_SWAP_MEM: begin
                    nxt_st.we    = 1'b1;
                    nxt_st.wdata = {m[3:0], m[7:4]};
                end
                // nibbles exchanged into working
                xma_pkg::OP_SWAP_WORK: begin
                    nxt_st.work = {m[3:0], m[7:4]};
                end
                default: begin
                    // unknown or idle code does nothing
                    nxt_st.we = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    // asynchronous clear, then the clock-enabled copy

    // registers the state copy; clock enable low freezes everything
    // reset clears the dummy phase: a skip cut short by reset is lost
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff.work  <= xma_pkg::WORK_RST;
            st_ff.flags <= xma_pkg::FLAG_RST;
            st_ff.we    <= 1'b0;
            st_ff.wdata <= xma_pkg::WORK_RST;
            st_ff.ph    <= xma_pkg::PH_RUN;
        end else if (i_clk_en) begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    // handshake from the phase bit, data straight from flip-flops

    // ready and skip are the one phase bit seen from two sides;
    // both come from a flip-flop, so neither can glitch
    assign o_op_ready         = (st_ff.ph == xma_pkg::PH_RUN);
    assign o_skip             = (st_ff.ph == xma_pkg::PH_DUMMY);
    // write strobe lasts one enabled cycle; data holds after it
    assign o_mem_we           = st_ff.we;
    assign o_mem_wdata        = st_ff.wdata;
    assign o_working_register = st_ff.work;
    assign o_flags            = st_ff.flags;

endmodule // xma_alu

// ### testbench/xma_alu_checker.sv
// xma_alu_checker: port properties of the memory-direct alu.
// assumes: bound to every xma_alu, one clock, async low reset.
`timescale 1ns/1ps
module xma_alu_checker (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_clk_en,
    input wire logic       i_op_valid,
    input wire logic [4:0] i_op,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [2:0] i_bit_sel,
    input wire logic       o_op_ready,
    input wire logic       o_mem_we,
    input wire logic [7:0] o_mem_wdata,
    input wire logic [7:0] o_working_register,
    input wire logic [5:0] o_flags,
    input wire logic       o_skip
);
    // opcode accepted on this edge
    wire logic take_now = i_clk_en & i_op_valid & o_op_ready;
    logic       tk_ff; // an opcode was taken last edge
    logic [4:0] op_ff; // its code
    logic [7:0] rd_ff; // its memory byte
    logic [7:0] w_ff;  // working register before it
    logic [5:0] f_ff;  // flags before it
    logic [2:0] b_ff;  // its bit index
    // keep the operands so each result is judged one edge later
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tk_ff <= 1'b0;
        end else begin
            tk_ff <= take_now;
            op_ff <= i_op;
            rd_ff <= i_mem_rdata;
            w_ff  <= o_working_register;
            f_ff  <= o_flags;
            b_ff  <= i_bit_sel;
        end
    end
    default clocking dc @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////
    a_or_into_mem: assert property (
        tk_ff && op_ff == xma_pkg::OP_OR_INTO_MEMORY |-> o_mem_we &&
        o_mem_wdata == (w_ff | rd_ff) && o_flags[2] == (o_mem_wdata == 8'h00))
        else $error("or into memory wrong");
    a_rot_left_mem: assert property (
        tk_ff && op_ff == xma_pkg::OP_ROT_LEFT_MEM |-> o_mem_we &&
        o_mem_wdata == {rd_ff[6:0], rd_ff[7]} && o_flags == f_ff)
        else $error("left rotate into memory wrong");
    a_rot_carry_work: assert property (
        tk_ff && op_ff == xma_pkg::OP_ROT_LEFT_C_WORK |-> !o_mem_we &&
        o_working_register == {rd_ff[6:0], f_ff[0]} && o_flags[0] == rd_ff[7])
        else $error("left carry rotate wrong");
    a_rot_right_carry: assert property (
        tk_ff && op_ff == xma_pkg::OP_ROT_RIGHT_C_MEM |->
        o_mem_wdata == {f_ff[0], rd_ff[7:1]} && o_flags[0] == rd_ff[0])
        else $error("right carry rotate wrong");
    a_dec_skip_mem: assert property (
        tk_ff && op_ff == xma_pkg::OP_DEC_SKIP_MEM |-> o_flags == f_ff &&
        o_mem_wdata == rd_ff - 8'h01 && o_skip == (rd_ff == 8'h01))
        else $error("decrement skip wrong");
    a_inc_skip_work: assert property (
        tk_ff && op_ff == xma_pkg::OP_INC_SKIP_WORK |-> !o_mem_we &&
        o_working_register == rd_ff + 8'h01 && o_skip == (rd_ff == 8'hFF))
        else $error("increment skip wrong");
    a_bit_skip_test: assert property (
        tk_ff && op_ff == xma_pkg::OP_SKIP_NZ_BIT |->
        !o_mem_we && o_skip == rd_ff[b_ff])
        else $error("bit skip wrong");
    a_sub_carry_zero: assert property (
        tk_ff && op_ff == xma_pkg::OP_SUB_WORK |->
        o_working_register == w_ff - rd_ff && o_flags[0] == (w_ff >= rd_ff)
        && o_flags[2] == (w_ff == rd_ff))
        else $error("subtract result or flags wrong");
    a_skip_one_cycle: assert property (
        o_skip && i_clk_en |=> !o_skip && o_op_ready)
        else $error("dummy cycle not single");
    a_dummy_no_effect: assert property (
        o_skip && i_clk_en |=> !o_mem_we &&
        o_working_register == $past(o_working_register) &&
        o_flags == $past(o_flags))
        else $error("opcode acted in dummy cycle");
endmodule // xma_alu_checker

bind xma_alu xma_alu_checker xma_alu_checker_i (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_op_valid(i_op_valid),
    .i_op(i_op),
    .i_mem_rdata(i_mem_rdata),
    .i_bit_sel(i_bit_sel),
    .o_op_ready(o_op_ready),
    .o_mem_we(o_mem_we),
    .o_mem_wdata(o_mem_wdata),
    .o_working_register(o_working_register),
    .o_flags(o_flags),
    .o_skip(o_skip)
);

// ### testbench/tb_top.sv
// tb_top: directed tests of the memory-direct alu at its ports.
// assumes: xma_pkg compiled first; checker bound from its own file.
`timescale 1ns/1ps
module tb_top;
    logic       clk;      // 200 MHz clock
    logic       rst_n;    // async reset, low
    logic       clk_en;   // state advance enable
    logic       op_valid; // opcode present
    logic [4:0] op;       // opcode
    logic [7:0] rdata;    // memory byte
    logic [2:0] bit_sel;  // bit index
    logic       ready;    // alu takes opcodes
    logic       mem_we;   // memory write pulse
    logic [7:0] wdata;    // memory write byte
    logic [7:0] work;     // working register
    logic [5:0] flags;    // status flags
    logic       skip;     // dummy cycle
    int         fails;    // mismatches
    int         checked;  // comparisons
    xma_alu xma_alu_i (
        .i_sys_clk(clk),
        .i_rst_n(rst_n),
        .i_clk_en(clk_en),
        .i_op_valid(op_valid),
        .i_op(op),
        .i_mem_rdata(rdata),
        .i_bit_sel(bit_sel),
        .o_op_ready(ready),
        .o_mem_we(mem_we),
        .o_mem_wdata(wdata),
        .o_working_register(work),
        .o_flags(flags),
        .o_skip(skip)
    );
    // clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one opcode; ms = {writes memory, skips}; d is memory or work byte
    task automatic run(input logic [4:0] o, input logic [7:0] rd,
                       input logic [1:0] ms, input logic [7:0] d,
                       input logic [5:0] f);
        @(negedge clk);
        op = o;
        rdata = rd;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
        cmp("mem_we", 8'(ms[1]), 8'(mem_we));
        cmp("result", d, ms[1] ? wdata : work);
        cmp("flags", 8'(f), 8'(flags));
        cmp("skip", 8'(ms[0]), 8'(skip));
    endtask
    task automatic t_reset();
        cmp("work", 8'h00, work);
        cmp("flags", 8'h00, 8'(flags));
        cmp("ready", 8'h01, 8'(ready));
        $display("test reset done");
    endtask
    task automatic t_rotate();
        run(xma_pkg::OP_ROT_LEFT_MEM, 8'h81, 2'h2, 8'h03, 6'h00);
        run(xma_pkg::OP_ROT_LEFT_WORK, 8'h81, 2'h0, 8'h03, 6'h00);
        run(xma_pkg::OP_ROT_LEFT_C_MEM, 8'h81, 2'h2, 8'h02, 6'h01);
        run(xma_pkg::OP_ROT_LEFT_C_WORK, 8'h01, 2'h0, 8'h03, 6'h00);
        run(xma_pkg::OP_ROT_RIGHT_MEM, 8'h81, 2'h2, 8'hC0, 6'h00);
        run(xma_pkg::OP_ROT_RIGHT_WORK, 8'h01, 2'h0, 8'h80, 6'h00);
        run(xma_pkg::OP_ROT_RIGHT_C_MEM, 8'h81, 2'h2, 8'h40, 6'h01);
        run(xma_pkg::OP_ROT_RIGHT_C_WORK, 8'h02, 2'h0, 8'h81, 6'h00);
        $display("test rotate done");
    endtask
    task automatic t_logic();
        run(xma_pkg::OP_SET_ALL_MEM, 8'h12, 2'h2, 8'hFF, 6'h00);
        bit_sel = 3'h7;
        run(xma_pkg::OP_SET_BIT_MEM, 8'h00, 2'h2, 8'h80, 6'h00);
        bit_sel = 3'h0;
        run(xma_pkg::OP_SET_BIT_MEM, 8'h5A, 2'h2, 8'h5B, 6'h00);
        run(xma_pkg::OP_SWAP_MEM, 8'hA5, 2'h2, 8'h5A, 6'h00);
        run(xma_pkg::OP_SWAP_WORK, 8'hA0, 2'h0, 8'h0A, 6'h00);
        run(xma_pkg::OP_OR_INTO_MEMORY, 8'h50, 2'h2, 8'h5A, 6'h00);
        run(xma_pkg::OP_SWAP_WORK, 8'h00, 2'h0, 8'h00, 6'h00);
        run(xma_pkg::OP_OR_INTO_MEMORY, 8'h00, 2'h2, 8'h00, 6'h04);
        $display("test logic done");
    endtask
    task automatic t_skip();
        run(xma_pkg::OP_DEC_SKIP_MEM, 8'h05, 2'h2, 8'h04, 6'h04);
        run(xma_pkg::OP_DEC_SKIP_MEM, 8'h01, 2'h3, 8'h00, 6'h04);
        run(xma_pkg::OP_DEC_SKIP_WORK, 8'h01, 2'h1, 8'h00, 6'h04);
        run(xma_pkg::OP_INC_SKIP_MEM, 8'hFF, 2'h3, 8'h00, 6'h04);
        run(xma_pkg::OP_INC_SKIP_WORK, 8'h7F, 2'h0, 8'h80, 6'h04);
        run(xma_pkg::OP_INC_SKIP_WORK, 8'hFF, 2'h1, 8'h00, 6'h04);
        bit_sel = 3'h3;
        run(xma_pkg::OP_SKIP_NZ_BIT, 8'h08, 2'h1, 8'h00, 6'h04);
        run(xma_pkg::OP_SKIP_NZ_BIT, 8'hF7, 2'h0, 8'h00, 6'h04);
        run(xma_pkg::OP_SKIP_NZ_BYTE, 8'h00, 2'h0, 8'h00, 6'h04);
        run(xma_pkg::OP_SKIP_NZ_BYTE, 8'h40, 2'h1, 8'h00, 6'h04);
        $display("test skip done");
    endtask
    task automatic t_sub();
        run(xma_pkg::OP_SWAP_WORK, 8'h50, 2'h0, 8'h05, 6'h04);
        run(xma_pkg::OP_SUB_WORK, 8'h07, 2'h0, 8'hFE, 6'h10);
        run(xma_pkg::OP_SWAP_WORK, 8'h08, 2'h0, 8'h80, 6'h10);
        run(xma_pkg::OP_SUB_MEM, 8'h01, 2'h2, 8'h7F, 6'h19);
        run(xma_pkg::OP_SUB_BORROW_WORK, 8'h80, 2'h0, 8'h00, 6'h07);
        run(xma_pkg::OP_SUB_WORK, 8'h00, 2'h0, 8'h00, 6'h27);
        run(xma_pkg::OP_SUB_BORROW_WORK, 8'h00, 2'h0, 8'h00, 6'h27);
        run(xma_pkg::OP_SUB_BORROW_MEM, 8'h01, 2'h2, 8'hFF, 6'h10);
        run(xma_pkg::OP_SUB_BORROW_WORK, 8'h00, 2'h0, 8'hFF, 6'h10);
        $display("test subtract done");
    endtask
    // opcode held through the dummy cycle, then a frozen clock enable
    task automatic t_refuse();
        @(negedge clk);
        op = xma_pkg::OP_DEC_SKIP_MEM;
        rdata = 8'h01;
        op_valid = 1'b1;
        @(negedge clk);
        cmp("ready", 8'h00, 8'(ready));
        op = xma_pkg::OP_SET_ALL_MEM;
        @(negedge clk);
        op_valid = 1'b0;
        cmp("mem_we", 8'h00, 8'(mem_we));
        clk_en = 1'b0;
        run(xma_pkg::OP_SWAP_WORK, 8'h00, 2'h0, 8'hFF, 6'h10);
        clk_en = 1'b1;
        // an unused code leaves everything as it was
        run(5'h1F, 8'h00, 2'h0, 8'hFF, 6'h10);
        $display("test refuse done");
    endtask
    // reset in mid-run, with a dummy cycle pending, clears all state
    task automatic t_mid_reset();
        @(negedge clk);
        op = xma_pkg::OP_DEC_SKIP_MEM;
        rdata = 8'h01;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
        rst_n = 1'b0;
        @(negedge clk);
        cmp("skip", 8'h00, 8'(skip));
        cmp("ready", 8'h01, 8'(ready));
        cmp("work", 8'h00, work);
        cmp("flags", 8'h00, 8'(flags));
        rst_n = 1'b1;
        run(xma_pkg::OP_ROT_LEFT_C_WORK, 8'h80, 2'h0, 8'h00, 6'h01);
        $display("test mid reset done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // tests need under a hundred cycles; 4000 means a hang
    initial begin
        #20000;
        fails++;
        give_verdict();
    end
    initial begin
        fails = 0;
        checked = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        op_valid = 1'b0;
        op = 5'h00;
        rdata = 8'h00;
        bit_sel = 3'h0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_rotate();
        t_logic();
        t_skip();
        t_sub();
        t_refuse();
        t_mid_reset();
        give_verdict();
    end
endmodule // tb_top
